// ---- pkg/crm_pkg.sv ----
// constants for the core register set and its extended multiply/divide
// assumes an 8-bit special-function register port inside the core
package crm_pkg;
  // special-function register addresses
  localparam logic [7:0] SFR_SP       = 8'h81;
  localparam logic [7:0] SFR_PTR_LO   = 8'h82;
  localparam logic [7:0] SFR_PTR_HI   = 8'h83;
  localparam logic [7:0] SFR_PTR1_LO  = 8'h84;
  localparam logic [7:0] SFR_PTR1_HI  = 8'h85;
  localparam logic [7:0] SFR_INSCFG   = 8'h86;
  localparam logic [7:0] SFR_STATUS   = 8'hD0;
  localparam logic [7:0] SFR_ACC      = 8'hE0;
  localparam logic [7:0] SFR_B        = 8'hF0;
  localparam logic [7:0] SFR_AUX      = 8'hF1;
  // reset values
  localparam logic [7:0]  SP_RESET     = 8'h07;
  localparam logic [7:0]  BYTE_RESET   = 8'h00;
  localparam logic [15:0] PTR_RESET    = 16'h0000;
  // status word bit positions
  localparam int ST_CY   = 7;
  localparam int ST_AC   = 6;
  localparam int ST_UFA  = 5;
  localparam int ST_BSH  = 4;
  localparam int ST_BSL  = 3;
  localparam int ST_OV   = 2;
  localparam int ST_UFB  = 1;
  localparam int ST_PAR  = 0;
  // instruction configuration bit positions
  localparam int IC_WDIV = 3;
  localparam int IC_WMUL = 2;
  localparam int IC_PSEL = 0;
  // address space
  localparam int          UPPER_BIT  = 7;
  localparam logic [15:0] XRAM_SIZE  = 16'h0500;
endpackage : crm_pkg

// ---- rtl/crm_core_regs.sv ----
// core register set: accumulator, B, aux, stack pointer, status word,
// two data pointers, instruction configuration, address steering
// assumes all inputs come from core logic on the same clock
`timescale 1ns/100ps
module crm_core_regs
  import crm_pkg::*;
(
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_clk_en,
  input  wire logic [7:0]  i_sfr_addr,
  input  wire logic        i_sfr_wr,
  input  wire logic        i_sfr_rd,
  input  wire logic [7:0]  i_sfr_wdata,
  output logic      [7:0]  o_sfr_rdata,
  output logic             o_sfr_hit,
  input  wire logic        i_acc_we,
  input  wire logic [7:0]  i_acc_wdata,
  output logic      [7:0]  o_acc,
  input  wire logic        i_sp_inc,
  input  wire logic        i_sp_dec,
  output logic      [7:0]  o_sp,
  input  wire logic        i_flag_we,
  input  wire logic        i_flag_cy,
  input  wire logic        i_flag_ac,
  input  wire logic        i_flag_ov,
  output logic      [7:0]  o_psw,
  input  wire logic        i_mul,
  input  wire logic        i_div,
  output logic             o_md_done,
  input  wire logic        i_primary_data_pointer_we,
  input  wire logic [15:0] i_primary_data_pointer_wdata,
  input  wire logic        i_primary_data_pointer_inc,
  output logic      [15:0] o_primary_data_pointer,
  input  wire logic [7:0]  i_mem_addr,
  input  wire logic        i_indirect,
  output logic             o_sel_sfr,
  output logic             o_sel_lower,
  output logic             o_sel_upper,
  input  wire logic [2:0]  i_reg_num,
  output logic      [7:0]  o_bank_addr,
  input  wire logic        i_xram_ri_form,
  input  wire logic [7:0]  i_ri_value,
  output logic      [10:0] o_xram_addr,
  output logic             o_xram_ok
);
  logic [7:0]  acc_q, acc_d, b_q, b_d, aux_q, aux_d, sp_q, sp_d;
  logic [7:1]  st_q, st_d;
  logic        wdiv_q, wdiv_d, wmul_q, wmul_d, psel_q, psel_d;
  logic [7:0]  rdata_q, rdata_d;
  logic        hit_q, hit_d, done_q, done_d;
  logic        sfr_q, sfr_d, low_q, low_d, up_q, up_d;
  logic [7:0]  bank_q, bank_d;
  logic [10:0] xa_q, xa_d;
  logic        xok_q, xok_d;
  logic        parity;
  logic [7:0]  status;
  logic [15:0] ptr0, ptr1, ptr_sel;
  logic [7:0]  m_acc, m_b, m_aux, d_acc, d_b, d_aux;
  logic        m_ov, d_ov;
  logic        wr;

  assign wr     = i_sfr_wr;
  assign parity = ^acc_q;
  assign status = {st_q, parity};

  crm_muldiv u_md (
    .i_acc      (acc_q),
    .i_b        (b_q),
    .i_aux      (aux_q),
    .i_wide_mul (wmul_q),
    .i_wide_div (wdiv_q),
    .o_mul_acc  (m_acc),
    .o_mul_b    (m_b),
    .o_mul_aux  (m_aux),
    .o_mul_ov   (m_ov),
    .o_div_acc  (d_acc),
    .o_div_b    (d_b),
    .o_div_aux  (d_aux),
    .o_div_ov   (d_ov)
  );

  // pointer word ops reach only the selected pointer
  crm_ptr u_ptr0 (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_clk_en  (i_clk_en),
    .i_lo_we   (wr && i_sfr_addr == SFR_PTR_LO),
    .i_hi_we   (wr && i_sfr_addr == SFR_PTR_HI),
    .i_byte    (i_sfr_wdata),
    .i_word_we (i_primary_data_pointer_we && !psel_q),
    .i_word    (i_primary_data_pointer_wdata),
    .i_inc     (i_primary_data_pointer_inc && !psel_q),
    .o_ptr     (ptr0)
  );

  crm_ptr u_ptr1 (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_clk_en  (i_clk_en),
    .i_lo_we   (wr && i_sfr_addr == SFR_PTR1_LO),
    .i_hi_we   (wr && i_sfr_addr == SFR_PTR1_HI),
    .i_byte    (i_sfr_wdata),
    .i_word_we (i_primary_data_pointer_we && psel_q),
    .i_word    (i_primary_data_pointer_wdata),
    .i_inc     (i_primary_data_pointer_inc && psel_q),
    .o_ptr     (ptr1)
  );

  assign ptr_sel = psel_q ? ptr1 : ptr0;

  // register state; core operations win over a same-cycle register write, except pointer byte writes, which win over word ops in crm_ptr
  always_comb begin
    acc_d  = acc_q;
    b_d    = b_q;
    aux_d  = aux_q;
    sp_d   = sp_q;
    st_d   = st_q;
    wdiv_d = wdiv_q;
    wmul_d = wmul_q;
    psel_d = psel_q;
    done_d = 1'b0;
    if (wr) begin
      case (i_sfr_addr)
        SFR_ACC:    acc_d = i_sfr_wdata;
        SFR_B:      b_d   = i_sfr_wdata;
        SFR_AUX:    aux_d = i_sfr_wdata;
        SFR_SP:     sp_d  = i_sfr_wdata;
        SFR_STATUS: st_d  = i_sfr_wdata[7:1];
        SFR_INSCFG: begin
          wdiv_d = i_sfr_wdata[IC_WDIV];
          wmul_d = i_sfr_wdata[IC_WMUL];
          psel_d = i_sfr_wdata[IC_PSEL];
        end
        default: ;
      endcase
    end
    if (i_acc_we) begin
      acc_d = i_acc_wdata;
    end
    if (i_sp_inc) begin
      sp_d = sp_q + 8'h01;
    end else if (i_sp_dec) begin
      sp_d = sp_q - 8'h01;
    end
    if (i_flag_we) begin
      st_d[ST_CY] = i_flag_cy;
      st_d[ST_AC] = i_flag_ac;
      st_d[ST_OV] = i_flag_ov;
    end
    if (i_mul) begin
      acc_d       = m_acc;
      b_d         = m_b;
      aux_d       = m_aux;
      st_d[ST_CY] = 1'b0;
      st_d[ST_OV] = m_ov;
      done_d      = 1'b1;
    end else if (i_div) begin
      acc_d       = d_acc;
      b_d         = d_b;
      aux_d       = d_aux;
      st_d[ST_CY] = 1'b0;
      st_d[ST_OV] = d_ov;
      done_d      = 1'b1;
    end
  end

  // read port and address steering, registered
  always_comb begin
    hit_d   = 1'b1;
    rdata_d = rdata_q;
    case (i_sfr_addr)
      SFR_ACC:     rdata_d = acc_q;
      SFR_B:       rdata_d = b_q;
      SFR_AUX:     rdata_d = aux_q;
      SFR_SP:      rdata_d = sp_q;
      SFR_STATUS:  rdata_d = status;
      SFR_PTR_LO:  rdata_d = ptr0[7:0];
      SFR_PTR_HI:  rdata_d = ptr0[15:8];
      SFR_PTR1_LO: rdata_d = ptr1[7:0];
      SFR_PTR1_HI: rdata_d = ptr1[15:8];
      SFR_INSCFG:  rdata_d = {4'h0, wdiv_q, wmul_q, 1'b0, psel_q};
      default: begin
        rdata_d = BYTE_RESET;
        hit_d   = 1'b0;
      end
    endcase
    if (!i_sfr_rd) begin
      rdata_d = rdata_q;
      hit_d   = 1'b0;
    end
    // top half of the space splits by addressing mode
    low_d  = !i_mem_addr[UPPER_BIT];
    up_d   = i_mem_addr[UPPER_BIT] && i_indirect;
    sfr_d  = i_mem_addr[UPPER_BIT] && !i_indirect;
    bank_d = {3'b000, st_q[ST_BSH], st_q[ST_BSL], i_reg_num};
    if (i_xram_ri_form) begin
      xa_d  = {3'b000, i_ri_value};
      xok_d = 1'b1;
    end else begin
      xa_d  = ptr_sel[10:0];
      xok_d = ptr_sel < XRAM_SIZE;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      acc_q   <= BYTE_RESET;
      b_q     <= BYTE_RESET;
      aux_q   <= BYTE_RESET;
      sp_q    <= SP_RESET;
      st_q    <= 7'h00;
      wdiv_q  <= 1'b0;
      wmul_q  <= 1'b0;
      psel_q  <= 1'b0;
      done_q  <= 1'b0;
      rdata_q <= BYTE_RESET;
      hit_q   <= 1'b0;
      low_q   <= 1'b0;
      up_q    <= 1'b0;
      sfr_q   <= 1'b0;
      bank_q  <= BYTE_RESET;
      xa_q    <= 11'h000;
      xok_q   <= 1'b0;
    end else if (i_clk_en) begin
      acc_q   <= acc_d;
      b_q     <= b_d;
      aux_q   <= aux_d;
      sp_q    <= sp_d;
      st_q    <= st_d;
      wdiv_q  <= wdiv_d;
      wmul_q  <= wmul_d;
      psel_q  <= psel_d;
      done_q  <= done_d;
      rdata_q <= rdata_d;
      hit_q   <= hit_d;
      low_q   <= low_d;
      up_q    <= up_d;
      sfr_q   <= sfr_d;
      bank_q  <= bank_d;
      xa_q    <= xa_d;
      xok_q   <= xok_d;
    end
  end

  assign o_acc       = acc_q;
  assign o_sp        = sp_q;
  assign o_psw       = status;
  assign o_md_done   = done_q;
  assign o_primary_data_pointer      = ptr_sel;
  assign o_sfr_rdata = rdata_q;
  assign o_sfr_hit   = hit_q;
  assign o_sel_lower = low_q;
  assign o_sel_upper = up_q;
  assign o_sel_sfr   = sfr_q;
  assign o_bank_addr = bank_q;
  assign o_xram_addr = xa_q;
  assign o_xram_ok   = xok_q;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  property p_sp_reset;
    $past(i_rst_n) == 1'b0 |-> o_sp == SP_RESET && o_psw == 8'h00;
  endproperty
  a_sp_reset: assert property (p_sp_reset) else $error("bad reset value");

  property p_sp_inc;
    i_clk_en && i_sp_inc && !i_mul && !i_div |=> o_sp == $past(o_sp) + 8'h01;
  endproperty
  a_sp_inc: assert property (p_sp_inc) else $error("push did not increment");

  property p_sp_dec;
    i_clk_en && i_sp_dec && !i_sp_inc |=> o_sp == $past(o_sp) - 8'h01;
  endproperty
  a_sp_dec: assert property (p_sp_dec) else $error("pop did not decrement");

  property p_parity;
    o_psw[ST_PAR] == ^o_acc;
  endproperty
  a_parity: assert property (p_parity) else $error("parity mismatch");

  property p_mul8;
    i_clk_en && i_mul && !wmul_q
      |=> {b_q, o_acc} == {8'h00, $past(acc_q)} * {8'h00, $past(b_q)};
  endproperty
  a_mul8: assert property (p_mul8) else $error("narrow multiply wrong");

  property p_md_flags;
    i_clk_en && (i_mul || i_div) |=> !o_psw[ST_CY] && o_md_done;
  endproperty
  a_md_flags: assert property (p_md_flags) else $error("carry not cleared");

  property p_div0;
    i_clk_en && i_div && !i_mul && b_q == 8'h00 |=> o_psw[ST_OV];
  endproperty
  a_div0: assert property (p_div0) else $error("zero divisor not flagged");

  property p_bank;
    i_clk_en ##1 i_clk_en && $stable(st_q)
      |-> o_bank_addr == {3'b000, st_q[ST_BSH], st_q[ST_BSL], $past(i_reg_num)};
  endproperty
  a_bank: assert property (p_bank) else $error("bank address wrong");

  property p_split;
    i_clk_en |=> (o_sel_lower ^ o_sel_upper ^ o_sel_sfr)
                 && (o_sel_upper == ($past(i_mem_addr[UPPER_BIT]) && $past(i_indirect)));
  endproperty
  a_split: assert property (p_split) else $error("address split wrong");

  property p_psel;
    o_primary_data_pointer == (psel_q ? ptr1 : ptr0) && ($past(i_clk_en) || ptr1 == $past(ptr1));
  endproperty
  a_psel: assert property (p_psel) else $error("pointer select wrong");
endmodule : crm_core_regs

// ---- rtl/crm_muldiv.sv ----
// combinational 8/16-bit multiply and divide datapath
// assumes the caller registers the results in one cycle
`timescale 1ns/100ps
module crm_muldiv
  import crm_pkg::*;
(
  input  wire logic [7:0] i_acc,
  input  wire logic [7:0] i_b,
  input  wire logic [7:0] i_aux,
  input  wire logic       i_wide_mul,
  input  wire logic       i_wide_div,
  output logic      [7:0] o_mul_acc,
  output logic      [7:0] o_mul_b,
  output logic      [7:0] o_mul_aux,
  output logic            o_mul_ov,
  output logic      [7:0] o_div_acc,
  output logic      [7:0] o_div_b,
  output logic      [7:0] o_div_aux,
  output logic            o_div_ov
);
  logic [23:0] prod;
  logic [15:0] num;
  logic [15:0] den;
  logic [15:0] quo;
  logic [15:0] rem;

  always_comb begin
    prod      = {8'h00, (i_wide_mul ? i_aux : 8'h00), i_acc} * {16'h0000, i_b};
    o_mul_acc = prod[7:0];
    o_mul_b   = prod[15:8];
    // narrow mode leaves the aux register untouched
    o_mul_aux = i_wide_mul ? prod[23:16] : i_aux;
    o_mul_ov  = i_wide_mul ? (prod[23:16] != 8'h00) : (prod[15:8] != 8'h00);
    num       = {(i_wide_div ? i_aux : 8'h00), i_acc};
    den       = {8'h00, i_b};
    // zero divisor: operands kept, only the overflow flag reports it
    quo       = (i_b == 8'h00) ? num : num / den;
    rem       = (i_b == 8'h00) ? den : num % den;
    o_div_acc = quo[7:0];
    o_div_b   = (i_b == 8'h00) ? i_b : rem[7:0];
    o_div_aux = (i_wide_div && i_b != 8'h00) ? quo[15:8] : i_aux;
    o_div_ov  = (i_b == 8'h00);
  end
endmodule : crm_muldiv

// ---- rtl/crm_ptr.sv ----
// one 16-bit data pointer, writable as two bytes or as a word
// assumes the caller gives at most one write source per cycle
`timescale 1ns/100ps
module crm_ptr
  import crm_pkg::*;
(
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_clk_en,
  input  wire logic        i_lo_we,
  input  wire logic        i_hi_we,
  input  wire logic [7:0]  i_byte,
  input  wire logic        i_word_we,
  input  wire logic [15:0] i_word,
  input  wire logic        i_inc,
  output logic      [15:0] o_ptr
);
  logic [15:0] ptr_q;
  logic [15:0] ptr_d;

  always_comb begin
    ptr_d = ptr_q;
    if (i_word_we) begin
      ptr_d = i_word;
    end else if (i_inc) begin
      ptr_d = ptr_q + 16'h0001;
    end
    if (i_lo_we) begin
      ptr_d[7:0] = i_byte;
    end
    if (i_hi_we) begin
      ptr_d[15:8] = i_byte;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      ptr_q <= PTR_RESET;
    end else if (i_clk_en) begin
      ptr_q <= ptr_d;
    end
  end

  assign o_ptr = ptr_q;
endmodule : crm_ptr

// ---- tb/cpu_core_regs_muldiv_test.sv ----
// self-checking bench for the core register set and multiply/divide
// assumes crm_pkg is compiled first; inputs change on the falling edge
`timescale 1ns/100ps
module cpu_core_regs_muldiv_test;
  import crm_pkg::*;
  logic        i_ref_clk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic        i_clk_en = 1'b1;
  logic [7:0]  i_sfr_addr = 8'h00;
  logic        i_sfr_wr = 1'b0;
  logic        i_sfr_rd = 1'b0;
  logic [7:0]  i_sfr_wdata = 8'h00;
  logic        i_acc_we = 1'b0;
  logic [7:0]  i_acc_wdata = 8'h00;
  logic        i_sp_inc = 1'b0;
  logic        i_sp_dec = 1'b0;
  logic        i_flag_we = 1'b0;
  logic [2:0]  i_flags = 3'b000;
  logic        i_mul = 1'b0;
  logic        i_div = 1'b0;
  logic        i_primary_data_pointer_we = 1'b0;
  logic [15:0] i_primary_data_pointer_wdata = 16'h0000;
  logic        i_primary_data_pointer_inc = 1'b0;
  logic [7:0]  i_mem_addr = 8'h00;
  logic        i_indirect = 1'b0;
  logic [2:0]  i_reg_num = 3'h0;
  logic        i_xram_ri_form = 1'b0;
  logic [7:0]  i_ri_value = 8'h00;
  logic [7:0]  o_sfr_rdata, o_acc, o_sp, o_psw, o_bank_addr;
  logic        o_sfr_hit, o_md_done, o_sel_sfr, o_sel_lower, o_sel_upper, o_xram_ok;
  logic [15:0] o_primary_data_pointer;
  logic [10:0] o_xram_addr;
  int          err_count = 0;
  int          total_checks = 0;
  int          cycles = 0;
  // {address, indirect, sfr/lower/upper}
  localparam logic [11:0] STEER [6] = '{{8'h10, 1'b0, 3'b010}, {8'h10, 1'b1, 3'b010},
    {8'h7F, 1'b0, 3'b010}, {8'h80, 1'b1, 3'b001}, {8'h90, 1'b1, 3'b001}, {8'h90, 1'b0, 3'b100}};
  localparam logic [7:0] PAR_VALS [5] = '{8'h00, 8'h01, 8'hFE, 8'hFF, 8'h03};

  crm_core_regs crm_core_regs_inst (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_clk_en(i_clk_en),
    .i_sfr_addr(i_sfr_addr), .i_sfr_wr(i_sfr_wr), .i_sfr_rd(i_sfr_rd),
    .i_sfr_wdata(i_sfr_wdata), .o_sfr_rdata(o_sfr_rdata), .o_sfr_hit(o_sfr_hit),
    .i_acc_we(i_acc_we), .i_acc_wdata(i_acc_wdata), .o_acc(o_acc),
    .i_sp_inc(i_sp_inc), .i_sp_dec(i_sp_dec), .o_sp(o_sp),
    .i_flag_we(i_flag_we), .i_flag_cy(i_flags[2]), .i_flag_ac(i_flags[1]),
    .i_flag_ov(i_flags[0]), .o_psw(o_psw), .i_mul(i_mul), .i_div(i_div),
    .o_md_done(o_md_done), .i_primary_data_pointer_we(i_primary_data_pointer_we), .i_primary_data_pointer_wdata(i_primary_data_pointer_wdata),
    .i_primary_data_pointer_inc(i_primary_data_pointer_inc), .o_primary_data_pointer(o_primary_data_pointer), .i_mem_addr(i_mem_addr),
    .i_indirect(i_indirect), .o_sel_sfr(o_sel_sfr), .o_sel_lower(o_sel_lower),
    .o_sel_upper(o_sel_upper), .i_reg_num(i_reg_num), .o_bank_addr(o_bank_addr),
    .i_xram_ri_form(i_xram_ri_form), .i_ri_value(i_ri_value),
    .o_xram_addr(o_xram_addr), .o_xram_ok(o_xram_ok));

  always #12.5 i_ref_clk = ~i_ref_clk;

  // hang guard: far above the length of the whole sequence
  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles > 20000) begin
      err_count++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic step();
    @(negedge i_ref_clk);
  endtask : step

  // strobe dropped then one idle edge, so back-to-back calls never re-drive a strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_sfr_addr = a;
    i_sfr_wdata = d;
    i_sfr_wr = 1'b1;
    step();
    i_sfr_wr = 1'b0;
    step();
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic hit);
    i_sfr_addr = a;
    i_sfr_rd = 1'b1;
    step();
    check("read data", o_sfr_rdata, exp);
    check("read hit", o_sfr_hit, hit);
    i_sfr_rd = 1'b0;
    step();
  endtask : rd

  task automatic flags(input logic [2:0] f);
    i_flags = f;
    i_flag_we = 1'b1;
    step();
    i_flag_we = 1'b0;
    step();
  endtask : flags

  task automatic sp_op(input logic inc, input logic [7:0] exp);
    i_sp_inc = inc;
    i_sp_dec = ~inc;
    step();
    i_sp_inc = 1'b0;
    i_sp_dec = 1'b0;
    check("stack pointer", o_sp, exp);
    step();
  endtask : sp_op

  // cfg of FF leaves the configuration untouched
  task automatic md(input logic dv, input logic [7:0] cfg, aux, a, b, ea, eb, ex,
                    input logic eov);
    if (cfg != 8'hFF) begin
      wr(SFR_INSCFG, cfg);
    end
    wr(SFR_AUX, aux);
    wr(SFR_ACC, a);
    wr(SFR_B, b);
    flags({1'b1, 1'b0, ~eov});
    i_mul = ~dv;
    i_div = dv;
    step();
    i_mul = 1'b0;
    i_div = 1'b0;
    check("done", o_md_done, 1'b1);
    check("acc result", o_acc, ea);
    check("carry", o_psw[ST_CY], 1'b0);
    check("overflow", o_psw[ST_OV], eov);
    rd(SFR_B, eb, 1'b1);
    rd(SFR_AUX, ex, 1'b1);
  endtask : md

  task automatic test_reset();
    check("sp reset", o_sp, SP_RESET);
    check("status reset", o_psw, 8'h00);
    check("pointer reset", o_primary_data_pointer, 16'h0000);
    rd(SFR_INSCFG, 8'h00, 1'b1);
    sp_op(1'b1, 8'h08);
    md(1'b0, 8'hFF, 8'h55, 8'hC8, 8'h03, 8'h58, 8'h02, 8'h55, 1'b1);
    wr(SFR_INSCFG, 8'hFF);
    rd(SFR_INSCFG, 8'h0D, 1'b1);
    rd(8'h87, 8'h00, 1'b0);
  endtask : test_reset

  task automatic test_ptr();
    wr(SFR_INSCFG, 8'h00);
    wr(SFR_PTR_LO, 8'h34);
    wr(SFR_PTR_HI, 8'h12);
    wr(SFR_PTR1_LO, 8'h78);
    wr(SFR_PTR1_HI, 8'h56);
    check("primary", o_primary_data_pointer, 16'h1234);
    wr(SFR_INSCFG, 8'h01);
    check("secondary", o_primary_data_pointer, 16'h5678);
    i_primary_data_pointer_wdata = 16'h04FF;
    i_primary_data_pointer_we = 1'b1;
    step();
    i_primary_data_pointer_we = 1'b0;
    step();
    check("word write", o_primary_data_pointer, 16'h04FF);
    check("xram in range", {o_xram_ok, 4'h0, o_xram_addr}, 16'h84FF);
    rd(SFR_PTR_LO, 8'h34, 1'b1);
    rd(SFR_PTR1_HI, 8'h04, 1'b1);
    i_primary_data_pointer_inc = 1'b1;
    step();
    i_primary_data_pointer_inc = 1'b0;
    step();
    check("xram over top", o_xram_ok, 1'b0);
    i_xram_ri_form = 1'b1;
    i_ri_value = 8'hAB;
    step();
    step();
    check("xram ri", {o_xram_ok, 4'h0, o_xram_addr}, 16'h80AB);
    i_xram_ri_form = 1'b0;
  endtask : test_ptr

  task automatic test_space();
    for (int k = 0; k < 6; k++) begin
      {i_mem_addr, i_indirect} = STEER[k][11:3];
      step();
      check("steering", {o_sel_sfr, o_sel_lower, o_sel_upper}, STEER[k][2:0]);
    end
  endtask : test_space

  task automatic test_status();
    for (int k = 0; k < 5; k++) begin
      i_acc_wdata = PAR_VALS[k];
      i_acc_we = 1'b1;
      step();
      i_acc_we = 1'b0;
      check("parity", o_psw[ST_PAR], ^PAR_VALS[k]);
      step();
    end
    for (int k = 0; k < 4; k++) begin
      wr(SFR_STATUS, {3'b001, 2'(k), 3'b011});
      i_reg_num = 3'(k + 3);
      step();
      check("status write", o_psw, {3'b001, 2'(k), 3'b010});
      check("bank address", o_bank_addr, 8'(k * 8 + k + 3));
    end
    flags(3'b111);
    check("flags set", {o_psw[7:6], o_psw[2]}, 3'b111);
    flags(3'b010);
    check("flags mixed", {o_psw[7:6], o_psw[2]}, 3'b010);
    wr(SFR_SP, 8'hFE);
    sp_op(1'b1, 8'hFF);
    sp_op(1'b1, 8'h00);
    sp_op(1'b0, 8'hFF);
    i_clk_en = 1'b0;
    sp_op(1'b1, 8'hFF);
    i_clk_en = 1'b1;
  endtask : test_status

  initial begin
    repeat (6) step();
    i_rst_n = 1'b1;
    step();
    test_reset();
    wr(SFR_INSCFG, 8'h00);
    md(1'b0, 8'h00, 8'h55, 8'h10, 8'h03, 8'h30, 8'h00, 8'h55, 1'b0);
    md(1'b0, 8'h04, 8'h12, 8'h34, 8'h10, 8'h40, 8'h23, 8'h01, 1'b1);
    md(1'b0, 8'h04, 8'h00, 8'h34, 8'h10, 8'h40, 8'h03, 8'h00, 1'b0);
    md(1'b1, 8'h00, 8'h55, 8'h64, 8'h07, 8'h0E, 8'h02, 8'h55, 1'b0);
    md(1'b1, 8'h08, 8'h01, 8'h00, 8'h03, 8'h55, 8'h01, 8'h00, 1'b0);
    md(1'b1, 8'h08, 8'h01, 8'h22, 8'h00, 8'h22, 8'h00, 8'h01, 1'b1);
    test_ptr();
    test_space();
    test_status();
    end_sim();
  end
endmodule : cpu_core_regs_muldiv_test
